/* inc/mecl_pkg.sv */
// shared constants and types of the meter event and compare logic
package mecl_pkg;
  // clock rate and documented times, counts derived from them
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned EVT_DEB_MS = 30;
  localparam int unsigned LOW_MIN_MS = 15;
  localparam int unsigned CANCEL_MS = 1000;
  localparam logic [23:0] EVT_DEB_CYC = 24'(EVT_DEB_MS * CYC_PER_MS);
  localparam logic [23:0] LOW_MIN_CYC = 24'(LOW_MIN_MS * CYC_PER_MS);
  localparam logic [23:0] CANCEL_CYC = 24'(CANCEL_MS * CYC_PER_MS);
  localparam logic [23:0] HI_PASS_CYC = 24'h000001;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HYST = 8'h04;
  localparam logic [7:0] ADDR_OMODE = 8'h08;
  localparam logic [7:0] ADDR_SET1A = 8'h0c;
  localparam logic [7:0] ADDR_SET1B = 8'h10;
  localparam logic [7:0] ADDR_SET2A = 8'h14;
  localparam logic [7:0] ADDR_SET2B = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [7:0] ADDR_PV = 8'h24;
  localparam logic [7:0] ADDR_OFFS = 8'h28;
  // field positions and reset values
  localparam int unsigned CTRL_ITYPE = 0;
  localparam int unsigned CTRL_EFUNC = 2;
  localparam int unsigned CTRL_SPEED = 3;
  localparam int unsigned CTRL_COLOUR = 4;
  localparam int unsigned CMD_TARE = 0;
  localparam int unsigned CMD_CANCEL = 1;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [13:0] HYST_RST = 14'h0001;
  localparam logic [13:0] HYST_MIN = 14'h0001;
  localparam logic [13:0] HYST_MAX = 14'h270f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // modes
  typedef enum logic [1:0] {
    IT_ANALOG = 2'h0,
    IT_REMOTE = 2'h1,
    IT_PULSE = 2'h2,
    IT_SPARE = 2'h3
  } mecl_itype_e;
  typedef enum logic [1:0] {
    ACT_UPPER = 2'h0,
    ACT_LOWER = 2'h1,
    ACT_RANGE = 2'h2,
    ACT_OFF = 2'h3
  } mecl_act_e;
  typedef enum logic [1:0] {
    CL_G2R = 2'h0,
    CL_GREEN = 2'h1,
    CL_RED = 2'h2,
    CL_R2G = 2'h3
  } mecl_colour_e;
  localparam logic EF_FREEZE = 1'h0;
  localparam logic EF_TARE = 1'h1;
endpackage : mecl_pkg

/* rtl/mecl_filt.sv */
// chatter filter for the shared event / pulse terminal
`timescale 1ns/1ps
module mecl_filt (
  input logic core_clk,
  input logic rstn,
  input logic din,
  input logic [23:0] limit,
  output logic lvl,
  output logic rise
);
  typedef struct packed {
    logic lvl;
    logic [23:0] cnt;
    logic rise;
  } mecl_filt_s;
  mecl_filt_s r;
  mecl_filt_s n;

  // level changes only after the input has differed for limit cycles
  always_comb
  begin
    n = r;
    n.rise = 1'h0;
    if (din == r.lvl)
      n.cnt = '0;
    else if (r.cnt >= limit - 24'h1)
    begin
      n.lvl = din;
      n.cnt = '0;
      n.rise = din;
    end
    else
      n.cnt = r.cnt + 24'h1;
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end

  assign lvl = r.lvl;
  assign rise = r.rise;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  switch_wait_a:
    assert property ($changed(r.lvl) |->
      $past(r.cnt) == $past(limit) - 24'h1 && $past(din) == r.lvl)
    else $error("filtered level moved before the window");
endmodule : mecl_filt

/* rtl/mecl_cmp.sv */
// one comparative output with hysteresis
`timescale 1ns/1ps
module mecl_cmp (
  input logic core_clk,
  input logic rstn,
  input logic upd,
  input logic [1:0] act,
  input logic [31:0] set_a,
  input logic [31:0] set_b,
  input logic [13:0] hyst,
  input logic [31:0] pv,
  output logic on
);
  typedef struct packed {
    logic on;
  } mecl_cmp_s;
  mecl_cmp_s r;
  mecl_cmp_s n;
  logic signed [33:0] p;
  logic signed [33:0] a;
  logic signed [33:0] b;
  logic signed [33:0] h;
  logic up_on, up_off, lo_on, lo_off, rg_on, rg_off;

  // widened so a limit plus or minus hysteresis never wraps
  assign p = 34'(signed'(pv));
  assign a = 34'(signed'(set_a));
  assign b = 34'(signed'(set_b));
  assign h = 34'(hyst);
  assign up_on = p >= a;
  assign up_off = p <= a - h;
  assign lo_on = p <= a;
  assign lo_off = p >= a + h;
  assign rg_on = (p >= a) || (p <= b);
  assign rg_off = (p <= a - h) && (p >= b + h);

  // evaluate once per update, hold inside the band
  always_comb
  begin
    n = r;
    if (upd)
    begin
      unique case (mecl_pkg::mecl_act_e'(act))
        mecl_pkg::ACT_UPPER:
          n.on = up_on ? 1'h1 : (up_off ? 1'h0 : r.on);
        mecl_pkg::ACT_LOWER:
          n.on = lo_on ? 1'h1 : (lo_off ? 1'h0 : r.on);
        mecl_pkg::ACT_RANGE:
          n.on = rg_on ? 1'h1 : (rg_off ? 1'h0 : r.on);
        mecl_pkg::ACT_OFF:
          n.on = 1'h0;
      endcase
    end
  end

  // state register, output starts off
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end

  assign on = r.on;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  upper_on_a:
    assert property (upd && act == mecl_pkg::ACT_UPPER && up_on |=> on)
    else $error("upper action did not turn on");
  lower_off_a:
    assert property (upd && act == mecl_pkg::ACT_LOWER && lo_off
      && !lo_on |=> !on)
    else $error("lower action did not turn off");
  range_on_a:
    assert property (upd && act == mecl_pkg::ACT_RANGE && rg_on |=> on)
    else $error("range action did not turn on");
  band_hold_a:
    assert property (upd && act == mecl_pkg::ACT_UPPER && !up_on
      && !up_off |=> on == $past(on))
    else $error("output moved inside hysteresis band");
endmodule : mecl_cmp

/* rtl/mecl_core.sv */
// event conditioning, hold, tare and compare core with axi4-lite registers
`timescale 1ns/1ps
// Notes on behaviour
// - terminal is event input for analog or remote, pulse input for pulse
// - a setting assigns the event input to freeze or to tare
// - event mode filters chatter for 30 ms; levels of 40 ms pass
// - 30 Hz pulse setting filters; on and off levels need 15 ms
// - 5 kHz pulse setting skips filtering; 90 us levels are accepted
// - freeze rising captures the value and keeps showing it while active
// - freeze released: live process value shown again
// - freeze works only for analog, remote or spare with freeze assigned
// - pulse type disables tare and ignores front key tare requests
// - tare takes current value as zero; later values are relative
// - tare while tare active re-zeros at the current value
// - tare input held one second cancels the offset
// - key tare and cancel are saved; terminal tare is not saved
// - terminal tare after key tare: terminal offset takes effect
// - cancel while no tare is active does nothing
// - tare requests come from front key, terminal and serial link
// - each of two outputs is upper, lower, outside-range or off
// - upper: on at value >= set, off at value <= set - hyst
// - lower: on at value <= set, off at value >= set + hyst
// - range: on outside limits, off inside limits narrowed by hyst
// - hysteresis accepts only 1 to 9999
// - colour: green to red, green, red, or red to green on output
// - outputs re-evaluated on every process value update
module mecl_core #(
  parameter logic [23:0] EVT_CYC = mecl_pkg::EVT_DEB_CYC,
  parameter logic [23:0] LOW_CYC = mecl_pkg::LOW_MIN_CYC,
  parameter logic [23:0] CANCEL_CYC = mecl_pkg::CANCEL_CYC
) (
  input logic core_clk,
  input logic rstn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic evt_pin,
  input logic [31:0] pv_in,
  input logic pv_stb,
  input logic key_tare,
  input logic key_cancel,
  input logic nv_load,
  input logic nv_tare_in,
  input logic [31:0] nv_offs_in,
  output logic pulse_stb,
  output logic [31:0] pv_out,
  output logic [1:0] cmp_out,
  output logic disp_red,
  output logic nv_save,
  output logic nv_tare,
  output logic [31:0] nv_offs
);
  typedef struct packed {
    logic [5:0] ctrl;
    logic [13:0] hyst;
    logic [3:0] omode;
    logic [3:0][31:0] setv;
    logic [31:0] raw;
    logic [31:0] pv;
    logic [31:0] offs;
    logic tare_on;
    logic [23:0] ccnt;
    logic cdone;
    logic [1:0] upd;
    logic red;
    logic nv_save;
    logic nv_tare;
    logic [31:0] nv_offs;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } mecl_core_s;

  localparam mecl_core_s CORE_RST = '{
    ctrl: mecl_pkg::CTRL_RST,
    hyst: mecl_pkg::HYST_RST,
    default: '0
  };

  mecl_core_s r;
  mecl_core_s n;
  logic ptype, tare_en, ev_tfn, hold, flvl, frise, lvl;
  logic aw_hs, w_hs, ar_hs, wr_go, cmd_wr;
  logic ev_tare, ev_cancel, key_t, key_c, cm_t, cm_c, any_t, any_c;
  logic cmp_any;
  logic [1:0] cmp_on;
  logic [23:0] flim;
  logic [31:0] eff_off;
  logic [31:0] live;
  logic [31:0] stat;
  logic [32:0] old_rd;
  logic [32:0] new_rd;
  logic [31:0] wr_val;

  // register read mux, top bit flags a mapped address
  function automatic logic [32:0] reg_rd(
    input mecl_core_s s,
    input logic [7:0] a,
    input logic [31:0] st
  );
    logic [32:0] v;
    v = {1'h1, 32'h0};
    case (a)
      mecl_pkg::ADDR_CTRL: v[31:0] = {26'h0, s.ctrl};
      mecl_pkg::ADDR_HYST: v[31:0] = {18'h0, s.hyst};
      mecl_pkg::ADDR_OMODE: v[31:0] = {28'h0, s.omode};
      mecl_pkg::ADDR_SET1A: v[31:0] = s.setv[0];
      mecl_pkg::ADDR_SET1B: v[31:0] = s.setv[1];
      mecl_pkg::ADDR_SET2A: v[31:0] = s.setv[2];
      mecl_pkg::ADDR_SET2B: v[31:0] = s.setv[3];
      mecl_pkg::ADDR_CMD: v[31:0] = 32'h0;
      mecl_pkg::ADDR_STAT: v[31:0] = st;
      mecl_pkg::ADDR_PV: v[31:0] = s.pv;
      mecl_pkg::ADDR_OFFS: v[31:0] = s.offs;
      default: v = 33'h0;
    endcase
    return v;
  endfunction : reg_rd

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        v[8*i +: 8] = nw[8*i +: 8];
    return v;
  endfunction : merge_bytes

  // terminal routing: event level or pulse edges by input type
  assign ptype = r.ctrl[mecl_pkg::CTRL_ITYPE +: 2] == mecl_pkg::IT_PULSE;
  assign ev_tfn = r.ctrl[mecl_pkg::CTRL_EFUNC] == mecl_pkg::EF_TARE;
  assign flim = !ptype ? EVT_CYC :
    (r.ctrl[mecl_pkg::CTRL_SPEED] ? mecl_pkg::HI_PASS_CYC : LOW_CYC);
  assign lvl = !ptype && flvl;
  assign pulse_stb = ptype && frise;

  mecl_filt u_filt (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(evt_pin),
    .limit(flim),
    .lvl(flvl),
    .rise(frise)
  );

  // freeze gate and presented value
  assign hold = lvl && !ev_tfn;
  assign tare_en = !ptype;
  assign eff_off = (tare_en && r.tare_on) ? r.offs : 32'h0;
  assign live = r.raw - eff_off;

  // tare and cancel requests from key, terminal and serial link
  assign ev_tare = tare_en && ev_tfn && frise;
  assign ev_cancel = lvl && ev_tfn && tare_en && !r.cdone
    && r.ccnt == CANCEL_CYC - 24'h1;
  assign key_t = tare_en && key_tare;
  assign key_c = tare_en && key_cancel;
  assign cmd_wr = wr_go && r.aw_addr == mecl_pkg::ADDR_CMD && r.w_strb[0];
  assign cm_t = tare_en && cmd_wr && r.w_data[mecl_pkg::CMD_TARE];
  assign cm_c = tare_en && cmd_wr && r.w_data[mecl_pkg::CMD_CANCEL];
  assign any_t = ev_tare || key_t || cm_t;
  assign any_c = ev_cancel || key_c || cm_c;

  // bus handshakes: one write and one read in flight
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_go = r.aw_got && r.w_got && !r.bvalid;
  assign stat = {26'h0, r.red, lvl, r.tare_on, hold, cmp_on};
  assign old_rd = reg_rd(r, r.aw_addr, stat);
  assign new_rd = reg_rd(r, s_axi_araddr, stat);
  assign wr_val = merge_bytes(old_rd[31:0], r.w_data, r.w_strb);
  assign cmp_any = |cmp_on;

  // next-state logic
  always_comb
  begin
    n = r;
    n.upd = {r.upd[0], pv_stb};
    n.nv_save = 1'h0;
    if (pv_stb)
      n.raw = pv_in;
    // freeze keeps the captured value, release shows live again
    n.pv = hold ? r.pv : live;

    // one second hold counter for terminal cancel
    if (lvl && ev_tfn && tare_en)
    begin
      if (!r.cdone)
        n.ccnt = r.ccnt + 24'h1;
      if (ev_cancel)
        n.cdone = 1'h1;
    end
    else
    begin
      n.ccnt = '0;
      n.cdone = 1'h0;
    end

    // latest tare wins; cancel only acts on an active tare
    if (any_t)
    begin
      n.offs = r.raw;
      n.tare_on = 1'h1;
    end
    else if (any_c && r.tare_on)
    begin
      n.offs = 32'h0;
      n.tare_on = 1'h0;
    end
    else if (nv_load)
    begin
      n.offs = nv_offs_in;
      n.tare_on = nv_tare_in;
    end
    // only key actions go to nonvolatile storage
    if (key_t || key_c)
      n.nv_save = 1'h1;
    n.nv_tare = n.tare_on;
    n.nv_offs = n.offs;

    // display colour from the comparative outputs
    unique case (mecl_pkg::mecl_colour_e'(r.ctrl[mecl_pkg::CTRL_COLOUR +: 2]))
      mecl_pkg::CL_G2R: n.red = cmp_any;
      mecl_pkg::CL_GREEN: n.red = 1'h0;
      mecl_pkg::CL_RED: n.red = 1'h1;
      mecl_pkg::CL_R2G: n.red = !cmp_any;
    endcase

    // write channel capture
    if (aw_hs)
    begin
      n.aw_got = 1'h1;
      n.aw_addr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      n.w_got = 1'h1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end

    // register write and response
    if (wr_go)
    begin
      n.aw_got = 1'h0;
      n.w_got = 1'h0;
      n.bvalid = 1'h1;
      n.bresp = mecl_pkg::RESP_OKAY;
      case (r.aw_addr)
        mecl_pkg::ADDR_CTRL: n.ctrl = wr_val[5:0];
        mecl_pkg::ADDR_HYST:
          if (wr_val >= 32'(mecl_pkg::HYST_MIN)
            && wr_val <= 32'(mecl_pkg::HYST_MAX))
            n.hyst = wr_val[13:0];
          else
            n.bresp = mecl_pkg::RESP_SLVERR;
        mecl_pkg::ADDR_OMODE: n.omode = wr_val[3:0];
        mecl_pkg::ADDR_SET1A: n.setv[0] = wr_val;
        mecl_pkg::ADDR_SET1B: n.setv[1] = wr_val;
        mecl_pkg::ADDR_SET2A: n.setv[2] = wr_val;
        mecl_pkg::ADDR_SET2B: n.setv[3] = wr_val;
        mecl_pkg::ADDR_CMD: n.bresp = mecl_pkg::RESP_OKAY;
        default: n.bresp = mecl_pkg::RESP_SLVERR;
      endcase
    end
    else if (r.bvalid && s_axi_bready)
      n.bvalid = 1'h0;

    // read channel
    if (ar_hs)
    begin
      n.rvalid = 1'h1;
      n.rdata = new_rd[31:0];
      n.rresp = new_rd[32] ? mecl_pkg::RESP_OKAY : mecl_pkg::RESP_SLVERR;
    end
    else if (r.rvalid && s_axi_rready)
      n.rvalid = 1'h0;
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      r <= CORE_RST;
    else
      r <= n;
  end

  // comparative outputs, one per channel
  for (genvar i = 0; i < 2; i++)
  begin : g_cmp
    mecl_cmp u_cmp (
      .core_clk(core_clk),
      .rstn(rstn),
      .upd(r.upd[1]),
      .act(r.omode[2*i +: 2]),
      .set_a(r.setv[2*i]),
      .set_b(r.setv[2*i+1]),
      .hyst(r.hyst),
      .pv(r.pv),
      .on(cmp_on[i])
    );
  end

  // outputs
  assign pv_out = r.pv;
  assign cmp_out = cmp_on;
  assign disp_red = r.red;
  assign nv_save = r.nv_save;
  assign nv_tare = r.nv_tare;
  assign nv_offs = r.nv_offs;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence tare_req_s;
    any_t;
  endsequence
  sequence zeroed_s;
    r.tare_on && r.offs == $past(r.raw);
  endsequence

  pulse_route_a:
    assert property (ptype |-> !lvl && !hold)
    else $error("event level seen in pulse mode");
  hold_keep_a:
    assert property (hold |=> r.pv == $past(r.pv))
    else $error("held value changed");
  live_back_a:
    assert property (!hold |=> r.pv == $past(live))
    else $error("live value not presented");
  freeze_gate_a:
    assert property (hold |-> !ptype && !ev_tfn)
    else $error("freeze outside its mode");
  pulse_tare_a:
    assert property (ptype && !nv_load |-> eff_off == 32'h0
      ##1 $stable(r.tare_on))
    else $error("tare acted in pulse mode");
  tare_zero_a:
    assert property (tare_req_s |=> zeroed_s)
    else $error("tare did not take current value");
  cancel_time_a:
    assert property (ev_cancel && !any_t |->
      r.ccnt == CANCEL_CYC - 24'h1 ##1 !r.tare_on && r.offs == 32'h0)
    else $error("terminal cancel timing wrong");
  key_save_a:
    assert property (key_t |=> r.nv_save && r.nv_tare)
    else $error("key tare not saved");
  evt_nosave_a:
    assert property ((ev_tare || ev_cancel) && !key_t && !key_c
      |=> !r.nv_save)
    else $error("terminal tare saved");
  idle_cancel_a:
    assert property (any_c && !any_t && !r.tare_on && !nv_load
      |=> !r.tare_on && $stable(r.offs))
    else $error("cancel acted with no tare");
  hyst_range_a:
    assert property (r.hyst >= mecl_pkg::HYST_MIN
      && r.hyst <= mecl_pkg::HYST_MAX)
    else $error("hysteresis out of range");
  colour_g2r_a:
    assert property (r.ctrl[5:4] == mecl_pkg::CL_G2R && $stable(r.ctrl)
      |=> r.red == $past(cmp_any))
    else $error("green to red colour wrong");
endmodule : mecl_core

/* verif/mecl_sw_model.sv */
// model of the contact or transistor switch on the event terminal
`timescale 1ns/1ps
module mecl_sw_model (
  input wire logic core_clk,
  output logic sw_out
);
  initial sw_out = 1'h0;
  // n pulses of on and off cycles, each turn-on led by b bounce cycles
  task automatic burst(input int n, input int on, input int off,
    input int b);
    repeat (n)
    begin
      repeat (b)
      begin
        @(posedge core_clk);
        sw_out <= ~sw_out;
      end
      @(posedge core_clk);
      sw_out <= 1'h1;
      repeat (on) @(posedge core_clk);
      sw_out <= 1'h0;
      repeat (off) @(posedge core_clk);
    end
    // hand back off the edge so counters updated on it have settled
    @(negedge core_clk);
  endtask : burst
endmodule : mecl_sw_model

/* verif/tb_top.sv */
// self-checking bench of the meter event and compare core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end
module tb_top;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, pv_in = 32'h0, nv_offs_in = 32'h5;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pv_stb = 1'h0;
  logic key_tare = 1'h0, key_cancel = 1'h0, nv_load = 1'h0;
  logic nv_tare_in = 1'h1, evt_pin;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pulse_stb, disp_red, nv_save, nv_tare;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmp_out, resp;
  logic [31:0] s_axi_rdata, pv_out, nv_offs, rdv;
  int err_count = 0, n_compared = 0, nsave = 0, npul = 0;
  // mode, process value, expected outputs
  logic [41:0] rows [11] = '{{8'h08, 32'h00000000, 2'h0},
    {8'h08, 32'h00000064, 2'h3}, {8'h08, 32'h00000061, 2'h3},
    {8'h08, 32'h0000005f, 2'h2}, {8'h08, 32'h0000002d, 2'h0},
    {8'h08, 32'hffffffce, 2'h2}, {8'h08, 32'hffffffd2, 2'h2},
    {8'h08, 32'hffffffd3, 2'h0}, {8'h0d, 32'hffffffd3, 2'h1},
    {8'h0d, 32'h00000068, 2'h1}, {8'h0d, 32'h00000069, 2'h0}};
  always #50 core_clk = ~core_clk;
  // core with shortened filter and cancel counts
  mecl_core #(.EVT_CYC(24'h000014), .LOW_CYC(24'h00000a),
    .CANCEL_CYC(24'h000032)) u_mecl_core (.core_clk, .rstn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .evt_pin, .pv_in, .pv_stb, .key_tare, .key_cancel,
    .nv_load, .nv_tare_in, .nv_offs_in, .pulse_stb, .pv_out, .cmp_out,
    .disp_red, .nv_save, .nv_tare, .nv_offs);
  mecl_sw_model u_mecl_sw_model (.core_clk, .sw_out(evt_pin));
  // count store requests and filtered pulses
  always @(posedge core_clk)
  begin
    if (nv_save === 1'h1)
      nsave <= nsave + 1;
    if (pulse_stb === 1'h1)
      npul <= npul + 1;
  end
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : cyc
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb)
        resp = s_axi_bresp;
      @(posedge core_clk);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
      if (tb)
        s_axi_bready <= 1'h0;
    end while (!tb);
  endtask : wr
  // axi4-lite read into rdv and resp
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ta)
        s_axi_arvalid <= 1'h0;
      if (tr)
        s_axi_rready <= 1'h0;
    end while (!tr);
  endtask : rd
  // one process value sample, then settle
  task automatic smp(input logic [31:0] v);
    @(posedge core_clk);
    pv_in <= v;
    pv_stb <= 1'h1;
    @(posedge core_clk);
    pv_stb <= 1'h0;
    cyc(5);
  endtask : smp
  task automatic key(input logic c);
    @(posedge core_clk);
    key_tare <= !c;
    key_cancel <= c;
    @(posedge core_clk);
    key_tare <= 1'h0;
    key_cancel <= 1'h0;
    cyc(3);
  endtask : key
  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    cyc(1);
    `CHK("cmp_out", 2'h0, cmp_out)
    rd(mecl_pkg::ADDR_HYST);
    `CHK("hyst", 32'h1, rdv)
    wr(mecl_pkg::ADDR_HYST, 32'h0);
    `CHK("bresp", mecl_pkg::RESP_SLVERR, resp)
    wr(mecl_pkg::ADDR_HYST, 32'h2710);
    `CHK("bresp", mecl_pkg::RESP_SLVERR, resp)
    wr(mecl_pkg::ADDR_HYST, 32'h270f);
    `CHK("bresp", mecl_pkg::RESP_OKAY, resp)
    rd(8'h2c);
    `CHK("rresp", mecl_pkg::RESP_SLVERR, resp)
    wr(mecl_pkg::ADDR_HYST, 32'h5);
    wr(mecl_pkg::ADDR_SET1A, 32'h64);
    wr(mecl_pkg::ADDR_SET2A, 32'h32);
    wr(mecl_pkg::ADDR_SET2B, 32'hffffffce);
    $display("test registers done");
    for (int i = 0; i < 11; i++)
    begin
      wr(mecl_pkg::ADDR_OMODE, {24'h0, rows[i][41:34]});
      smp(rows[i][33:2]);
      `CHK("cmp_out", rows[i][1:0], cmp_out)
      `CHK("disp_red", |rows[i][1:0], disp_red)
    end
    $display("test compare done");
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4)
        smp(32'h32);
      wr(mecl_pkg::ADDR_CTRL, 32'(k % 4) << 4);
      cyc(2);
      `CHK("colour", k > 3 ? k % 2 == 0 : k > 1, disp_red)
    end
    $display("test colour done");
    wr(mecl_pkg::ADDR_CTRL, 32'h1);
    smp(32'h7);
    fork
      u_mecl_sw_model.burst(1, 60, 2, 3);
      begin
        cyc(40);
        smp(32'h9);
        `CHK("pv_out", 32'h7, pv_out)
      end
    join
    cyc(30);
    `CHK("pv_out", 32'h9, pv_out)
    fork
      u_mecl_sw_model.burst(1, 10, 2, 0);
      smp(32'hb);
    join
    `CHK("pv_out", 32'hb, pv_out)
    $display("test freeze done");
    wr(mecl_pkg::ADDR_CTRL, 32'h4);
    smp(32'h1e);
    u_mecl_sw_model.burst(1, 30, 30, 0);
    `CHK("pv_out", 32'h0, pv_out)
    smp(32'h28);
    `CHK("pv_out", 32'ha, pv_out)
    u_mecl_sw_model.burst(1, 30, 30, 2);
    `CHK("pv_out", 32'h0, pv_out)
    u_mecl_sw_model.burst(1, 90, 30, 0);
    `CHK("pv_out", 32'h28, pv_out)
    `CHK("nsave", 0, nsave)
    key(1'h0);
    `CHK("nsave", 1, nsave)
    `CHK("nv_offs", 32'h28, nv_offs)
    `CHK("pv_out", 32'h0, pv_out)
    smp(32'h32);
    u_mecl_sw_model.burst(1, 30, 30, 0);
    `CHK("pv_out", 32'h0, pv_out)
    for (int j = 0; j < 3; j++)
    begin
      wr(mecl_pkg::ADDR_CMD, j == 2 ? 32'h1 : 32'h2);
      cyc(2);
      `CHK("pv_out", j == 2 ? 32'h0 : 32'h32, pv_out)
    end
    // restore a stored offset of 5, then cancel it from the key
    @(posedge core_clk);
    nv_load <= 1'h1;
    @(posedge core_clk);
    nv_load <= 1'h0;
    cyc(2);
    `CHK("pv_out", 32'h2d, pv_out)
    key(1'h1);
    `CHK("pv_out", 32'h32, pv_out)
    `CHK("nv_tare", 1'h0, nv_tare)
    `CHK("npul", 0, npul)
    $display("test tare done");
    wr(mecl_pkg::ADDR_CTRL, 32'ha);
    key(1'h0);
    u_mecl_sw_model.burst(3, 1, 1, 0);
    `CHK("npul", 3, npul)
    wr(mecl_pkg::ADDR_CTRL, 32'h2);
    u_mecl_sw_model.burst(3, 4, 4, 0);
    u_mecl_sw_model.burst(2, 12, 12, 2);
    `CHK("npul", 5, npul)
    `CHK("pv_out", 32'h32, pv_out)
    `CHK("nsave", 2, nsave)
    rd(mecl_pkg::ADDR_STAT);
    `CHK("tare_on", 1'h0, rdv[3])
    $display("test pulse done");
    // reset in mid-run while output 1 is on
    @(posedge core_clk);
    rstn <= 1'h0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    cyc(1);
    `CHK("cmp_out", 2'h0, cmp_out)
    rd(mecl_pkg::ADDR_HYST);
    `CHK("hyst", 32'h1, rdv)
    $display("test reset done");
    print_verdict();
  end
endmodule : tb_top
